/* File: logic/misc_pins_pkg.sv */
// Purpose: Shared constants and carrier types for the miscellaneous pin block.
// Assumes: APB with 32-bit data; register indices map to byte address index*4.
// Notes: Register offsets are all multiples of four, so they are kept as indices.
package misc_pins_pkg;

    localparam int APB_ADDR_W = 12;
    localparam int IDX_W = 8;
    localparam int EVT_W = 3;

    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_GP_BITS = 8'h07;
    localparam logic [IDX_W-1:0] IDX_GPCFG = 8'h35;
    localparam logic [IDX_W-1:0] IDX_DMA_CTRL = 8'h3B;
    localparam logic [IDX_W-1:0] IDX_FUNC_SEL = 8'h40;
    localparam logic [IDX_W-1:0] IDX_INT_STAT = 8'h41;
    localparam logic [IDX_W-1:0] IDX_INT_CLR = 8'h42;
    localparam logic [IDX_W-1:0] IDX_INT_EN = 8'h43;
    localparam logic [IDX_W-1:0] IDX_MISC_STAT = 8'h44;

    // Field positions.
    localparam int DMA_CTRL_TOTEM_BIT = 3;
    localparam int FUNC_FETCH_BIT = 0;
    localparam int FUNC_OWNER_BIT = 1;
    localparam int FUNC_MAC_BIT = 2;
    localparam int EVT_GP0_BIT = 0;
    localparam int EVT_GP1_BIT = 1;
    localparam int EVT_TEST_BIT = 2;
    localparam int MSTAT_TEST_BIT = 0;
    localparam int MSTAT_IRQ_BIT = 1;

    // Reset values.
    localparam logic [1:0] GPCFG_RST = 2'h0;
    localparam logic [1:0] GP_BITS_RST = 2'h0;
    localparam logic [2:0] FUNC_SEL_RST = 3'h0;
    localparam logic DMA_CTRL_TOTEM_RST = 1'b0;
    localparam logic [EVT_W-1:0] INT_EN_RST = 3'h0;

    typedef struct packed {
        logic o;
        logic oe;
    } pad_drive_s;

    typedef struct packed {
        logic opcode_fetch_next;
        logic bus_owner;
        logic mem_access_local;
        logic irq_condition;
    } core_status_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] gp_out_val;
        logic [1:0] gp_oe_cfg;
        logic [2:0] func_sel;
        logic irq_totem;
        logic [EVT_W-1:0] int_stat;
        logic [EVT_W-1:0] int_en;
        logic [1:0] gp_prev;
        logic test_prev;
        pad_drive_s gp0;
        pad_drive_s gp1;
        pad_drive_s mac;
        pad_drive_s irq;
        logic irq_asserted;
        logic int_req;
    } misc_state_s;

    localparam misc_state_s STATE_RST = '{
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        gp_out_val: GP_BITS_RST,
        gp_oe_cfg: GPCFG_RST,
        func_sel: FUNC_SEL_RST,
        irq_totem: DMA_CTRL_TOTEM_RST,
        int_stat: 3'h0,
        int_en: INT_EN_RST,
        gp_prev: 2'h3,
        test_prev: 1'b1,
        gp0: '{o: 1'b1, oe: 1'b0},
        gp1: '{o: 1'b1, oe: 1'b0},
        mac: '{o: 1'b0, oe: 1'b0},
        irq: '{o: 1'b0, oe: 1'b0},
        irq_asserted: 1'b0,
        int_req: 1'b0
    };

endpackage

/* File: logic/sync2.sv */
// Purpose: Two-stage synchroniser for levels that arrive from pins.
// Assumes: Inputs are slow levels; no pulse shorter than two clocks is expected.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Data.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

/* File: logic/misc_pins.sv */
// Purpose: Connectivity AND tree, two general-purpose pins, memory-access
//          indication and interrupt pin drive, with an APB register slave.
// Assumes: Pad cells combine out/oe/pull-up enable into the real wire level.
// Notes: The tree path and the test-mode tri-state gating are combinational.
//
// Overview of operation
// - Test input low ANDs pins, SCSI excluded.
// - Test mode: pull-ups on, outputs but the shared pin tri-stated.
// - Any tested pin low drives test output low.
// - Shared pin shows tree only in test.
// - Pin zero inputs at reset; optional fetch indication.
// - Pin one inputs at reset; optional ownership indication.
// - Pin zero via config index, level readable.
`timescale 1ns/100ps
module misc_pins
    import misc_pins_pkg::*;
#(
    parameter int TREE_PINS = 64
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Connectivity test.
    input wire logic connectivity_test_enable_n,
    input wire logic [TREE_PINS-1:0] tree_pin_in,
    output logic pullup_enable,
    output pad_drive_s memory_access_or_tree_out_pin,
    // General-purpose pins.
    input wire logic gp_pin_zero_in,
    output pad_drive_s gp_pin_zero,
    input wire logic gp_pin_one_in,
    output pad_drive_s gp_pin_one,
    // Core status and interrupt.
    input core_status_s core_status,
    output pad_drive_s irq_pin_n,
    output logic int_req
);

    misc_state_s st_reg;
    misc_state_s st_next;
    logic [1:0] gp_sync;
    logic test_n_sync;
    logic tree_and;
    logic access_phase;
    logic write_take;
    logic addr_ok;
    logic hit;
    logic [IDX_W-1:0] idx;
    logic [31:0] rd_data;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] clr;
    logic irq_assert;

    // Register map in word indices; the byte address is four times the index.
    // The general bits word takes the two output values on a write and returns
    // the synchronised levels of both general pins on a read, so software sees
    // the wire, not what it last wrote.
    // The general config word holds one output enable per general pin. Zero
    // keeps a pin an input, which is how both pins come out of reset.
    // The dma control word has one live bit, which picks totem-pole drive for
    // the interrupt pin instead of open drain.
    // The function select word overrides the general bits per pin: bit 0 turns
    // pin zero into the fetch flag, bit 1 turns pin one into the bus-owner flag
    // and bit 2 lets the shared pin show the memory-access flag.
    // The interrupt status word is sticky and read only. The clear word is
    // write-one-to-clear and reads as zero. The enable word masks the status
    // into int_req.
    // The misc status word shows test mode as the clocked side sees it, and
    // whether the interrupt is asserted, even while test mode floats the pin.
    // Any other index, or a misaligned address, ends in an error response and
    // writes nothing.

    // Pin levels cross into the clock domain through two flops before any
    // register reads them. Only the tree and the test-mode gating read raw pins.
    sync2 #(
        .WIDTH(2),
        .RST_VAL(2'h3)
    ) gp_sync_inst (
        .pclk(pclk),
        .presetn(presetn),
        .d({gp_pin_one_in, gp_pin_zero_in}),
        .q(gp_sync)
    );

    sync2 #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) test_sync_inst (
        .pclk(pclk),
        .presetn(presetn),
        .d(connectivity_test_enable_n),
        .q(test_n_sync)
    );

    // The tree sees the raw pins so it works with the clock stopped.
    // The pad ring must leave the SCSI lines out of tree_pin_in; this block
    // cannot tell which pins they are.
    assign tree_and = (&tree_pin_in) & gp_pin_zero_in & gp_pin_one_in;

    // A misaligned or out-of-range address is refused rather than aliased
    // onto a register.
    assign idx = paddr[IDX_W+1:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[APB_ADDR_W-1:IDX_W+2] == '0);
    // The access is taken once, in the cycle before pready; the write lands
    // at the pready edge, so it happens exactly once per transfer.
    assign access_phase = psel && penable && !st_reg.pready;
    assign write_take = psel && penable && st_reg.pready && pwrite;

    // Read mux and decode.
    always_comb
    begin
        rd_data = 32'h0000_0000;
        hit = 1'b1;
        if (!addr_ok)
        begin
            hit = 1'b0;
        end
        else if (idx == IDX_GP_BITS)
        begin
            rd_data[1:0] = gp_sync;
        end
        else if (idx == IDX_GPCFG)
        begin
            rd_data[1:0] = st_reg.gp_oe_cfg;
        end
        else if (idx == IDX_DMA_CTRL)
        begin
            rd_data[DMA_CTRL_TOTEM_BIT] = st_reg.irq_totem;
        end
        else if (idx == IDX_FUNC_SEL)
        begin
            rd_data[2:0] = st_reg.func_sel;
        end
        else if (idx == IDX_INT_STAT)
        begin
            rd_data[EVT_W-1:0] = st_reg.int_stat;
        end
        else if (idx == IDX_INT_CLR)
        begin
            // The clear word is write only, so a read shows nothing.
            rd_data = 32'h0000_0000;
        end
        else if (idx == IDX_INT_EN)
        begin
            rd_data[EVT_W-1:0] = st_reg.int_en;
        end
        else if (idx == IDX_MISC_STAT)
        begin
            rd_data[MSTAT_TEST_BIT] = !test_n_sync;
            rd_data[MSTAT_IRQ_BIT] = st_reg.irq_asserted;
        end
        else
        begin
            hit = 1'b0;
        end
    end

    always_comb
    begin
        st_next = st_reg;

        // Two-cycle access phase: pready rises one cycle after penable.
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (access_phase)
        begin
            st_next.pready = 1'b1;
            st_next.pslverr = !hit;
            st_next.prdata = (hit && !pwrite) ? rd_data : 32'h0000_0000;
        end

        // The status words are read only, so a write to them is dropped
        // without an error.
        clr = '0;
        if (write_take && hit)
        begin
            if (idx == IDX_GP_BITS)
            begin
                st_next.gp_out_val = pwdata[1:0];
            end
            else if (idx == IDX_GPCFG)
            begin
                st_next.gp_oe_cfg = pwdata[1:0];
            end
            else if (idx == IDX_DMA_CTRL)
            begin
                st_next.irq_totem = pwdata[DMA_CTRL_TOTEM_BIT];
            end
            else if (idx == IDX_FUNC_SEL)
            begin
                st_next.func_sel = pwdata[2:0];
            end
            else if (idx == IDX_INT_CLR)
            begin
                clr = pwdata[EVT_W-1:0];
            end
            else if (idx == IDX_INT_EN)
            begin
                st_next.int_en = pwdata[EVT_W-1:0];
            end
        end

        // The synchronisers and the edge history reset high, the idle level of
        // the pins, so the release of reset raises no false event.
        // Events: any edge on a general pin, and entry into test mode.
        evt = '0;
        evt[EVT_GP0_BIT] = gp_sync[0] ^ st_reg.gp_prev[0];
        evt[EVT_GP1_BIT] = gp_sync[1] ^ st_reg.gp_prev[1];
        evt[EVT_TEST_BIT] = st_reg.test_prev && !test_n_sync;
        st_next.gp_prev = gp_sync;
        st_next.test_prev = test_n_sync;
        // A new event outweighs a clear written in the same cycle.
        st_next.int_stat = (st_reg.int_stat & ~clr) | evt;
        st_next.int_req = |(st_next.int_stat & st_next.int_en);

        // Both flags are active low at the pin, so the core's high is inverted.
        // General pin zero: plain I/O, or low ahead of an opcode fetch.
        if (st_next.func_sel[FUNC_FETCH_BIT])
        begin
            st_next.gp0.oe = 1'b1;
            st_next.gp0.o = !core_status.opcode_fetch_next;
        end
        else
        begin
            st_next.gp0.oe = st_next.gp_oe_cfg[0];
            st_next.gp0.o = st_next.gp_out_val[0];
        end

        // General pin one: plain I/O, or low while this device owns the bus.
        if (st_next.func_sel[FUNC_OWNER_BIT])
        begin
            st_next.gp1.oe = 1'b1;
            st_next.gp1.o = !core_status.bus_owner;
        end
        else
        begin
            st_next.gp1.oe = st_next.gp_oe_cfg[1];
            st_next.gp1.o = st_next.gp_out_val[1];
        end

        // Outside test mode the shared pin floats unless its flag is enabled.
        st_next.mac.oe = st_next.func_sel[FUNC_MAC_BIT];
        st_next.mac.o = core_status.mem_access_local;

        // Open drain only pulls low; totem pole also drives the high level.
        irq_assert = st_next.int_req || core_status.irq_condition;
        st_next.irq_asserted = irq_assert;
        if (st_next.irq_totem)
        begin
            st_next.irq.oe = 1'b1;
            st_next.irq.o = !irq_assert;
        end
        else
        begin
            st_next.irq.oe = irq_assert;
            st_next.irq.o = 1'b0;
        end
    end

    // Reset brings every pin but the shared pin in test mode to an undriven input and every flag to zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= STATE_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Bus answers come straight from the state register.
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign int_req = st_reg.int_req;

    // Test mode must float every driver but the shared pin even with no clock, so the gating
    // uses the raw test input rather than the synchronised copy.
    assign pullup_enable = !connectivity_test_enable_n;
    assign gp_pin_zero.o = st_reg.gp0.o;
    assign gp_pin_zero.oe = st_reg.gp0.oe && connectivity_test_enable_n;
    assign gp_pin_one.o = st_reg.gp1.o;
    assign gp_pin_one.oe = st_reg.gp1.oe && connectivity_test_enable_n;
    assign irq_pin_n.o = st_reg.irq.o;
    assign irq_pin_n.oe = st_reg.irq.oe && connectivity_test_enable_n;

    // Shared pin: tree result in test mode, memory-access indication otherwise.
    assign memory_access_or_tree_out_pin.o =
        connectivity_test_enable_n ? st_reg.mac.o : tree_and;
    assign memory_access_or_tree_out_pin.oe =
        connectivity_test_enable_n ? st_reg.mac.oe : 1'b1;

endmodule

/* File: tb/tester_model.sv */
// Purpose: Board tester model driving the test input and tested pin levels.
// Assumes: Pins the tester leaves alone rest high, as the pull-ups hold them.
// Notes: Index TREE_PINS and TREE_PINS+1 select the two general-purpose pins.
`timescale 1ns/100ps
module tester_model #(
    parameter int TREE_PINS = 64
) (
    // Control from the bench.
    input wire logic test_on,
    input wire logic low_en,
    input wire logic [7:0] low_sel,
    // Pins toward the block.
    output logic connectivity_test_enable_n,
    output logic [TREE_PINS-1:0] tree_pin_in,
    output logic gp0_lvl,
    output logic gp1_lvl
);
    // Only one pin is ever pulled low, so a dead pin is identified by index.
    always_comb
    begin
        connectivity_test_enable_n = !test_on;
        for (int i = 0; i < TREE_PINS; i++)
        begin
            tree_pin_in[i] = !(low_en && low_sel == i);
        end
        gp0_lvl = !(low_en && low_sel == TREE_PINS);
        gp1_lvl = !(low_en && low_sel == TREE_PINS + 1);
    end
endmodule

/* File: tb/misc_pins_checker.sv */
// Purpose: Port-level assertions for the miscellaneous pin block.
// Assumes: One clock domain, pclk with reset presetn.
// Notes: Bound into misc_pins below the module.
`timescale 1ns/100ps
module misc_pins_checker
    import misc_pins_pkg::*;
#(
    parameter int TREE_PINS = 64
) (
    // Clock, reset and APB.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins.
    input wire logic connectivity_test_enable_n,
    input wire logic [TREE_PINS-1:0] tree_pin_in,
    input wire logic pullup_enable,
    input pad_drive_s memory_access_or_tree_out_pin,
    input wire logic gp_pin_zero_in,
    input pad_drive_s gp_pin_zero,
    input wire logic gp_pin_one_in,
    input pad_drive_s gp_pin_one,
    input pad_drive_s irq_pin_n,
    input wire logic int_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic tst;
    logic tree;
    pad_drive_s mac;
    assign tst = !connectivity_test_enable_n;
    assign tree = &tree_pin_in && gp_pin_zero_in && gp_pin_one_in;
    assign mac = memory_access_or_tree_out_pin;
    AST_TREE: assert property (tst |-> mac.oe && mac.o == tree)
        else $error("tree output wrong in test mode");
    AST_HIZ: assert property (tst |-> pullup_enable && !gp_pin_zero.oe && !gp_pin_one.oe
        && !irq_pin_n.oe)
        else $error("pin driven in test mode");
    AST_NOPULL: assert property (!tst |-> !pullup_enable)
        else $error("pull-ups on outside test mode");
    AST_RDY: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response malformed");
    AST_IRQ: assert property (int_req && !tst |-> irq_pin_n.oe && !irq_pin_n.o)
        else $error("interrupt pin not low");
    AST_GPRST: assert property ($rose(presetn) |-> !gp_pin_zero.oe && !gp_pin_one.oe)
        else $error("general-purpose pin not input after reset");
    cover property (tst && !mac.o);
    cover property (pslverr);
    cover property (int_req && !tst);
endmodule
bind misc_pins misc_pins_checker #(.TREE_PINS(TREE_PINS)) i_chk (.pclk, .presetn, .psel,
    .penable, .prdata, .pready, .pslverr, .connectivity_test_enable_n, .tree_pin_in,
    .pullup_enable, .memory_access_or_tree_out_pin, .gp_pin_zero_in, .gp_pin_zero,
    .gp_pin_one_in, .gp_pin_one, .irq_pin_n, .int_req);

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the miscellaneous pin block.
// Assumes: APB master waits on pready; tester model drives the pins.
// Notes: A small tree width keeps the one-pin-low sweep short.
`timescale 1ns/100ps
module tb_top;
    import misc_pins_pkg::*;
    localparam int NP = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, pullup_enable, int_req;
    logic test_on = 1'b0;
    logic low_en = 1'b0;
    logic [7:0] low_sel = 8'h00;
    logic test_n, gp0_lvl, gp1_lvl, gp0_in, gp1_in;
    logic [NP-1:0] tree;
    core_status_s cs = '0;
    pad_drive_s mac, gp0, gp1, irq;
    int fails = 0, checks_done = 0, cyc = 0;
    // Wire level: the pad wins while driven, else the tester or pull-up.
    assign gp0_in = gp0.oe ? gp0.o : gp0_lvl;
    assign gp1_in = gp1.oe ? gp1.o : gp1_lvl;
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end
    tester_model #(.TREE_PINS(NP)) i_tester (.test_on, .low_en, .low_sel,
        .connectivity_test_enable_n(test_n), .tree_pin_in(tree), .gp0_lvl, .gp1_lvl);
    misc_pins #(.TREE_PINS(NP)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .connectivity_test_enable_n(test_n),
        .tree_pin_in(tree), .pullup_enable, .memory_access_or_tree_out_pin(mac),
        .gp_pin_zero_in(gp0_in), .gp_pin_zero(gp0), .gp_pin_one_in(gp1_in),
        .gp_pin_one(gp1), .core_status(cs), .irq_pin_n(irq), .int_req);
    task summarize;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Register changes reach the pads at the edge that stores them; pin levels take a few edges more; levels, so no race.
    task settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task t_reset;
        chk({gp0.oe, gp1.oe}, 2'h0);
        apb(1'b0, IDX_GPCFG, 32'h0);
        chk(rd, GPCFG_RST);
        apb(1'b0, IDX_GP_BITS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, IDX_DMA_CTRL, 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_gpio;
        apb(1'b1, IDX_GPCFG, 32'h3);
        apb(1'b1, IDX_GP_BITS, 32'h2);
        settle();
        chk({gp0.oe, gp0.o, gp1.oe, gp1.o}, 4'hB);
        apb(1'b0, IDX_GP_BITS, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, IDX_FUNC_SEL, 32'h7);
        cs <= '{1'b1, 1'b1, 1'b1, 1'b0};
        settle();
        chk({gp0.oe, gp0.o, gp1.oe, gp1.o}, 4'hA);
        chk(mac.o, 1'b1);
        cs <= '0;
        settle();
        chk({gp0.o, gp1.o, mac.o}, 3'h6);
    endtask
    task t_tree;
        @(posedge pclk);
        test_on <= 1'b1;
        #1;
        chk({pullup_enable, gp0.oe, gp1.oe, irq.oe}, 4'h8);
        chk({mac.oe, mac.o}, 2'h3);
        for (int i = 0; i < NP + 2; i++)
        begin
            @(posedge pclk);
            low_en <= 1'b1;
            low_sel <= 8'(i);
            #1;
            chk(mac.o, 1'b0);
            @(posedge pclk);
            low_en <= 1'b0;
            #1;
            chk(mac.o, 1'b1);
        end
        @(posedge pclk);
        test_on <= 1'b0;
        apb(1'b1, IDX_FUNC_SEL, 32'h0);
        apb(1'b1, IDX_GPCFG, 32'h0);
    endtask
    task t_irq;
        apb(1'b1, IDX_INT_CLR, 32'h7);
        apb(1'b1, IDX_INT_EN, 32'h1);
        low_sel <= NP;
        low_en <= 1'b1;
        settle();
        settle();
        chk({int_req, irq.oe, irq.o}, 3'h6);
        apb(1'b1, IDX_DMA_CTRL, 32'h8);
        low_en <= 1'b0;
        settle();
        settle();
        chk({irq.oe, irq.o}, 2'h2);
        apb(1'b1, IDX_INT_CLR, 32'h1);
        settle();
        chk({int_req, irq.oe, irq.o}, 3'h3);
        apb(1'b1, IDX_INT_EN, 32'h0);
        low_en <= 1'b1;
        settle();
        settle();
        chk(int_req, 1'b0);
        apb(1'b0, IDX_INT_STAT, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
    endtask
    // Core interrupt condition, test-mode floating of an asserted interrupt,
    // separate fetch and owner flags, and a reset in mid-run.
    task t_misc;
        apb(1'b1, IDX_DMA_CTRL, 32'h0);
        low_en <= 1'b0;
        cs <= '{1'b0, 1'b0, 1'b0, 1'b1};
        settle();
        chk({int_req, irq.oe, irq.o}, 3'h2);
        apb(1'b0, IDX_MISC_STAT, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, IDX_INT_CLR, 32'h7);
        test_on <= 1'b1;
        settle();
        chk({pullup_enable, irq.oe, mac.oe}, 3'h5);
        apb(1'b0, IDX_MISC_STAT, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, IDX_INT_STAT, 32'h0);
        chk(rd, 32'h4);
        test_on <= 1'b0;
        cs <= '{1'b1, 1'b0, 1'b0, 1'b0};
        apb(1'b1, IDX_FUNC_SEL, 32'h3);
        settle();
        chk({irq.oe, gp0.oe, gp0.o, gp1.oe, gp1.o}, 5'h0B);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk({gp0.oe, gp1.oe, int_req}, 3'h0);
        apb(1'b0, IDX_FUNC_SEL, 32'h0);
        chk(rd, FUNC_SEL_RST);
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            fails++;
            summarize();
        end
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        t_reset();
        t_gpio();
        t_tree();
        t_irq();
        t_misc();
        summarize();
    end
endmodule
